// file: usb_bus_pkg.sv
// shared constants for the usb bus-state and interrupt-mask block
package usb_bus_pkg;

	// register byte offsets
	localparam logic [7:0] ADDR_BUS_CTRL  = 8'h00; // reset/resume/suspend/mode
	localparam logic [7:0] ADDR_BUS_STAT  = 8'h04; // speed and signalling state
	localparam logic [7:0] ADDR_GRP_SET   = 8'h08; // grouped mask enable
	localparam logic [7:0] ADDR_GRP_CLR   = 8'h0C; // grouped mask disable
	localparam logic [7:0] ADDR_GRP_MASK  = 8'h10; // grouped mask readback
	localparam logic [7:0] ADDR_CTL_SET   = 8'h14; // control mask enable
	localparam logic [7:0] ADDR_CTL_CLR   = 8'h18; // control mask disable
	localparam logic [7:0] ADDR_CTL_MASK  = 8'h1C; // control mask readback
	localparam logic [7:0] ADDR_CTL_STAT  = 8'h20; // control events, read clears
	localparam logic [7:0] ADDR_EP_SET    = 8'h24; // endpoint mask enable
	localparam logic [7:0] ADDR_EP_CLR    = 8'h28; // endpoint mask disable
	localparam logic [7:0] ADDR_EP_MASK   = 8'h2C; // endpoint mask readback
	localparam logic [7:0] ADDR_EP_STAT   = 8'h30; // endpoint events, w1c
	localparam logic [7:0] ADDR_GRP_STAT  = 8'h34; // group events, w1c

	// bus control bits
	localparam int BIT_RESET   = 0; // drive bus reset
	localparam int BIT_RESUME  = 1; // drive resume
	localparam int BIT_SUSPEND = 2; // suspend command (pulse)
	localparam int BIT_HOST    = 3; // 1 = host operation

	// grouped mask layout: four endpoints per field
	localparam int GRP_HOST_IN  = 0;  // host in endpoints 0..3
	localparam int GRP_HOST_OUT = 4;  // host out endpoints 0..3
	localparam int GRP_DEV_IN   = 8;  // device in endpoints 0..3
	localparam int GRP_DEV_OUT  = 12; // device out endpoints 0..3
	localparam int GRP_STATUS   = 16; // general status
	localparam int GRP_ALL_BIT  = 31; // all-sources selector
	localparam int GRP_W        = 17; // implemented group bits
	localparam int EP_GRP_N     = 4;  // endpoints covered by the group mask

	// control event flags
	localparam int CTL_W = 12;
	localparam int CTL_VBUS_ERR = 0;
	localparam int CTL_SESSION  = 1;
	localparam int CTL_SESS_END = 2;
	localparam int CTL_CONNECT  = 3;
	localparam int CTL_DISCONN  = 4;
	localparam int CTL_SOF      = 5;
	localparam int CTL_BABBLE   = 6;
	localparam int CTL_RESET    = 7;
	localparam int CTL_RESUME   = 8;
	localparam int CTL_SUSPEND  = 9;
	localparam int CTL_MODE_DET = 10;
	localparam int CTL_PWR_FLT  = 11;

	// endpoint flags: host in 0..15, host out 16..31 style packed halves
	localparam int EP_W = 32;

	// speed codes
	typedef enum logic [1:0] {
		speed_unknown = 2'b00,
		speed_low     = 2'b01,
		speed_full    = 2'b10
	} speed_e;

	// bus signalling state
	typedef enum logic [1:0] {
		BUS_IDLE    = 2'b00,
		BUS_RESET   = 2'b01,
		BUS_RESUME  = 2'b10,
		BUS_SUSPEND = 2'b11
	} bus_state_e;

	localparam logic [1:0] RESP_OKAY   = 2'b00; // axi okay
	localparam logic [1:0] RESP_SLVERR = 2'b10; // unmapped address
	localparam logic [31:0] ZERO32     = 32'h0000_0000;

endpackage

// file: usb_bus_ctrl.sv
// usb bus-state signalling and interrupt mask logic with axi4-lite slave
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps

module usb_bus_ctrl (
	input  wire logic        mclk,          // 200 MHz system clock
	input  wire logic        sys_rst,       // async reset, active high
	input  wire logic        clk_en,        // freezes all state when low
	input  wire logic [7:0]  s_axi_awaddr,  // write address
	input  wire logic        s_axi_awvalid, // write address valid
	output logic             s_axi_awready, // write address ready
	input  wire logic [31:0] s_axi_wdata,   // write data
	input  wire logic [3:0]  s_axi_wstrb,   // write strobes
	input  wire logic        s_axi_wvalid,  // write data valid
	output logic             s_axi_wready,  // write data ready
	output logic [1:0]       s_axi_bresp,   // write response
	output logic             s_axi_bvalid,  // write response valid
	input  wire logic        s_axi_bready,  // write response ready
	input  wire logic [7:0]  s_axi_araddr,  // read address
	input  wire logic        s_axi_arvalid, // read address valid
	output logic             s_axi_arready, // read address ready
	output logic [31:0]      s_axi_rdata,   // read data
	output logic [1:0]       s_axi_rresp,   // read response
	output logic             s_axi_rvalid,  // read data valid
	input  wire logic        s_axi_rready,  // read data ready
	input  wire logic [1:0]  line_speed,    // speed seen by phy
	input  wire logic [11:0] ctl_events,    // control event pulses
	input  wire logic [31:0] ep_events,     // endpoint event pulses
	output logic             drive_reset,   // phy: drive se0 reset
	output logic             drive_resume,  // phy: drive k resume
	output logic             bus_suspended, // phy: bus in suspend
	output logic             usb_irq        // level interrupt
);

	// software-visible state
	logic [3:0]                   bus_ctrl;   // reset/resume/host bits
	logic [usb_bus_pkg::GRP_W-1:0] grp_mask;  // grouped enables
	logic [usb_bus_pkg::GRP_W-1:0] grp_stat;  // grouped sticky events
	logic [usb_bus_pkg::CTL_W-1:0] ctl_mask;  // control enables
	logic [usb_bus_pkg::CTL_W-1:0] ctl_stat;  // control sticky events
	logic [usb_bus_pkg::EP_W-1:0]  ep_mask;   // endpoint enables
	logic [usb_bus_pkg::EP_W-1:0]  ep_stat;   // endpoint sticky events
	usb_bus_pkg::bus_state_e       bus_state; // signalling state
	usb_bus_pkg::speed_e           speed;     // latched speed

	// axi bookkeeping
	logic        aw_held;  // write address captured
	logic        w_held;   // write data captured
	logic [7:0]  aw_addr;  // captured write address
	logic [31:0] w_data;   // captured write data
	logic [3:0]  w_strb;   // captured strobes
	logic        wr_go;    // both halves present, commit this cycle
	logic        rd_go;    // read accepted this cycle
	logic        wr_hit;   // write address is mapped
	logic [31:0] wr_val;   // write data with unstrobed lanes zeroed

	// mapped check shared by read and write paths
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a <= usb_bus_pkg::ADDR_GRP_STAT) && (a[1:0] == 2'b00);
	endfunction

	// expand byte strobes into a bit mask
	function automatic logic [31:0] lanes(input logic [3:0] s);
		lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	// fold per-endpoint events of endpoints 0..3 into group events
	function automatic logic [usb_bus_pkg::GRP_W-1:0] grp_from_ep(
		input logic [31:0] e,
		input logic        host);
		logic [usb_bus_pkg::GRP_W-1:0] g;
		g = '0;
		if (host) begin
			g[usb_bus_pkg::GRP_HOST_IN  +: 4] = e[3:0];
			g[usb_bus_pkg::GRP_HOST_OUT +: 4] = e[19:16];
		end else begin
			g[usb_bus_pkg::GRP_DEV_IN   +: 4] = e[3:0];
			g[usb_bus_pkg::GRP_DEV_OUT  +: 4] = e[19:16];
		end
		grp_from_ep = g;
	endfunction

	assign wr_go  = aw_held && w_held && !s_axi_bvalid;
	assign rd_go  = s_axi_arvalid && s_axi_arready;
	assign wr_hit = mapped(aw_addr);
	assign wr_val = w_data & lanes(w_strb);

	// handshake readies are combinational; one beat of each held at most;
	// low while frozen, else a beat taken by the master would be lost
	assign s_axi_awready = clk_en && !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = clk_en && !w_held && !s_axi_bvalid;
	assign s_axi_arready = clk_en && !s_axi_rvalid;

	// capture write address and data in either order
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= usb_bus_pkg::ZERO32;
			w_strb  <= 4'h0;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_go) begin
				w_held <= 1'b0;
			end
		end
	end

	// write response one cycle after both halves are held
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= usb_bus_pkg::RESP_OKAY;
		end else if (clk_en) begin
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? usb_bus_pkg::RESP_OKAY
				                       : usb_bus_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read data mux, registered on acceptance
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= usb_bus_pkg::ZERO32;
			s_axi_rresp  <= usb_bus_pkg::RESP_OKAY;
		end else if (clk_en) begin
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= usb_bus_pkg::RESP_OKAY;
				s_axi_rdata  <= usb_bus_pkg::ZERO32;
				if (s_axi_araddr == usb_bus_pkg::ADDR_BUS_CTRL) begin
					s_axi_rdata[3:0] <= bus_ctrl;
				end else if (s_axi_araddr == usb_bus_pkg::ADDR_BUS_STAT) begin
					s_axi_rdata[3:0] <= {bus_state, speed};
				end else if (s_axi_araddr == usb_bus_pkg::ADDR_GRP_MASK) begin
					s_axi_rdata[usb_bus_pkg::GRP_W-1:0] <= grp_mask;
				end else if (s_axi_araddr == usb_bus_pkg::ADDR_CTL_MASK) begin
					s_axi_rdata[usb_bus_pkg::CTL_W-1:0] <= ctl_mask;
				end else if (s_axi_araddr == usb_bus_pkg::ADDR_CTL_STAT) begin
					s_axi_rdata[usb_bus_pkg::CTL_W-1:0] <= ctl_stat;
				end else if (s_axi_araddr == usb_bus_pkg::ADDR_EP_MASK) begin
					s_axi_rdata <= ep_mask;
				end else if (s_axi_araddr == usb_bus_pkg::ADDR_EP_STAT) begin
					s_axi_rdata <= ep_stat;
				end else if (s_axi_araddr == usb_bus_pkg::ADDR_GRP_STAT) begin
					s_axi_rdata[usb_bus_pkg::GRP_W-1:0] <= grp_stat;
				end else if (!mapped(s_axi_araddr)) begin
					s_axi_rresp <= usb_bus_pkg::RESP_SLVERR; // unmapped
				end
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// bus control: reset and resume are plain levels, no internal timer,
	// so software owns the 20 ms and 10-15 ms windows
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			bus_ctrl <= 4'h0;
		end else if (clk_en && wr_go && aw_addr == usb_bus_pkg::ADDR_BUS_CTRL
		             && w_strb[0]) begin
			bus_ctrl <= w_data[3:0];
			bus_ctrl[usb_bus_pkg::BIT_SUSPEND] <= 1'b0; // suspend is a pulse
		end
	end

	// bus signalling state; reset beats resume, resume beats suspend
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			bus_state <= usb_bus_pkg::BUS_IDLE;
		end else if (clk_en) begin
			case (bus_state)
				usb_bus_pkg::BUS_IDLE,
				usb_bus_pkg::BUS_SUSPEND: begin
					if (bus_ctrl[usb_bus_pkg::BIT_RESET]) begin
						bus_state <= usb_bus_pkg::BUS_RESET;
					end else if (bus_ctrl[usb_bus_pkg::BIT_RESUME]) begin
						bus_state <= usb_bus_pkg::BUS_RESUME;
					end else if (wr_go && aw_addr == usb_bus_pkg::ADDR_BUS_CTRL
					             && w_strb[0]
					             && w_data[usb_bus_pkg::BIT_SUSPEND]
					             && w_data[usb_bus_pkg::BIT_HOST]) begin
						bus_state <= usb_bus_pkg::BUS_SUSPEND;
					end
				end
				usb_bus_pkg::BUS_RESET: begin
					if (!bus_ctrl[usb_bus_pkg::BIT_RESET]) begin
						bus_state <= usb_bus_pkg::BUS_IDLE;
					end
				end
				usb_bus_pkg::BUS_RESUME: begin
					// dropping the request ends resume and leaves bus active
					if (bus_ctrl[usb_bus_pkg::BIT_RESET]) begin
						bus_state <= usb_bus_pkg::BUS_RESET;
					end else if (!bus_ctrl[usb_bus_pkg::BIT_RESUME]) begin
						bus_state <= usb_bus_pkg::BUS_IDLE;
					end
				end
				default: bus_state <= usb_bus_pkg::BUS_IDLE;
			endcase
		end
	end

	assign drive_reset   = (bus_state == usb_bus_pkg::BUS_RESET);
	assign drive_resume  = (bus_state == usb_bus_pkg::BUS_RESUME);
	assign bus_suspended = (bus_state == usb_bus_pkg::BUS_SUSPEND);

	// speed capture; any undefined code reads as unknown
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			speed <= usb_bus_pkg::speed_unknown;
		end else if (clk_en) begin
			case (line_speed)
				usb_bus_pkg::speed_low:  speed <= usb_bus_pkg::speed_low;
				usb_bus_pkg::speed_full: speed <= usb_bus_pkg::speed_full;
				default: speed <= usb_bus_pkg::speed_unknown;
			endcase
		end
	end

	// grouped mask: set/clear ports, bit 31 selects every source
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			grp_mask <= '0;
		end else if (clk_en && wr_go) begin
			if (aw_addr == usb_bus_pkg::ADDR_GRP_SET) begin
				if (wr_val[usb_bus_pkg::GRP_ALL_BIT]) begin
					grp_mask <= '1;
				end else begin
					grp_mask <= grp_mask | wr_val[usb_bus_pkg::GRP_W-1:0];
				end
			end else if (aw_addr == usb_bus_pkg::ADDR_GRP_CLR) begin
				if (wr_val[usb_bus_pkg::GRP_ALL_BIT]) begin
					grp_mask <= '0;
				end else begin
					grp_mask <= grp_mask & ~wr_val[usb_bus_pkg::GRP_W-1:0];
				end
			end
		end
	end

	// control mask: enable sets, disable clears
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ctl_mask <= '0;
		end else if (clk_en && wr_go) begin
			if (aw_addr == usb_bus_pkg::ADDR_CTL_SET) begin
				ctl_mask <= ctl_mask | wr_val[usb_bus_pkg::CTL_W-1:0];
			end else if (aw_addr == usb_bus_pkg::ADDR_CTL_CLR) begin
				ctl_mask <= ctl_mask & ~wr_val[usb_bus_pkg::CTL_W-1:0];
			end
		end
	end

	// endpoint mask, independent of the control mask
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ep_mask <= '0;
		end else if (clk_en && wr_go) begin
			if (aw_addr == usb_bus_pkg::ADDR_EP_SET) begin
				ep_mask <= ep_mask | wr_val;
			end else if (aw_addr == usb_bus_pkg::ADDR_EP_CLR) begin
				ep_mask <= ep_mask & ~wr_val;
			end
		end
	end

	// control status: cleared by its read, a same-cycle event survives
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ctl_stat <= '0;
		end else if (clk_en) begin
			if (rd_go && s_axi_araddr == usb_bus_pkg::ADDR_CTL_STAT) begin
				ctl_stat <= ctl_events;
			end else begin
				ctl_stat <= ctl_stat | ctl_events;
			end
		end
	end

	// endpoint and group status: write one to clear, set wins
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ep_stat  <= '0;
			grp_stat <= '0;
		end else if (clk_en) begin
			ep_stat  <= (ep_stat & ~((wr_go &&
			            aw_addr == usb_bus_pkg::ADDR_EP_STAT) ? wr_val
			            : usb_bus_pkg::ZERO32)) | ep_events;
			grp_stat <= (grp_stat & ~((wr_go &&
			            aw_addr == usb_bus_pkg::ADDR_GRP_STAT)
			            ? wr_val[usb_bus_pkg::GRP_W-1:0] : '0))
			            | grp_from_ep(ep_events, bus_ctrl[usb_bus_pkg::BIT_HOST])
			            | ({{(usb_bus_pkg::GRP_W-1){1'b0}}, |ctl_events}
			               << usb_bus_pkg::GRP_STATUS);
		end
	end

	// one level output; any enabled pending source asserts it
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			usb_irq <= 1'b0;
		end else if (clk_en) begin
			usb_irq <= |(grp_stat & grp_mask) | |(ctl_stat & ctl_mask)
			           | |(ep_stat & ep_mask);
		end
	end

endmodule

// file: usb_bus_ctrl_props.sv
// port-level assertions for the bus-state and mask block
`timescale 1ns/1ps
module usb_bus_ctrl_props (
	input wire logic        mclk,          // clock
	input wire logic        sys_rst,       // reset
	input wire logic [7:0]  s_axi_awaddr,  // aw
	input wire logic        s_axi_awvalid, // aw
	input wire logic        s_axi_awready, // aw
	input wire logic [31:0] s_axi_wdata,   // w
	input wire logic        s_axi_wvalid,  // w
	input wire logic        s_axi_wready,  // w
	input wire logic [1:0]  s_axi_bresp,   // b
	input wire logic        s_axi_bvalid,  // b
	input wire logic [7:0]  s_axi_araddr,  // ar
	input wire logic        s_axi_arvalid, // ar
	input wire logic        s_axi_arready, // ar
	input wire logic [31:0] s_axi_rdata,   // r
	input wire logic        s_axi_rvalid,  // r
	input wire logic        s_axi_rready,  // r
	input wire logic [1:0]  line_speed,    // phy speed
	input wire logic        drive_reset,   // reset signalling
	input wire logic        drive_resume,  // resume signalling
	input wire logic        bus_suspended  // suspend state
);
	logic [7:0]  wa; // last taken write address
	logic [31:0] wd; // last taken write data
	logic [7:0]  ra; // last taken read address
	logic        wc; // last write hit bus control
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	assign wc = (wa == usb_bus_pkg::ADDR_BUS_CTRL);
	// capture what each taken request carried, so effects tie to causes
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			wa <= 8'h00;
			wd <= 32'h0000_0000;
			ra <= 8'h00;
		end else begin
			if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata;
			if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
		end
	end
	a_reset_start: assert property (
		$rose(s_axi_bvalid) && wc && wd[0] |=> drive_reset)
		else $error("reset signalling did not start");
	a_reset_end: assert property (
		$fell(drive_reset) |-> $past(s_axi_bvalid) && wc)
		else $error("reset signalling ended without a request");
	a_resume_start: assert property (
		$rose(s_axi_bvalid) && wc && wd[1:0] == 2'b10 && !drive_reset
		|=> drive_resume && !bus_suspended)
		else $error("resume signalling did not start");
	a_resume_end: assert property (
		$fell(drive_resume) |-> $past(s_axi_bvalid) && wc)
		else $error("resume ended without a request");
	a_suspend_cmd: assert property (
		$rose(s_axi_bvalid) && wc && wd[3:0] == 4'b1100 |-> bus_suspended)
		else $error("host suspend not entered");
	a_suspend_host: assert property (
		$rose(bus_suspended) |-> $rose(s_axi_bvalid) && wc && wd[3:2] == 2'b11)
		else $error("suspend entered without host command");
	a_speed_code: assert property (
		$rose(s_axi_rvalid) && ra == usb_bus_pkg::ADDR_BUS_STAT
		|-> s_axi_rdata[1:0] == (($past(line_speed, 2) == 2'b01
		|| $past(line_speed, 2) == 2'b10) ? $past(line_speed, 2) : 2'b00))
		else $error("speed field wrong");
	a_unmapped_err: assert property (
		$rose(s_axi_bvalid) && wa > 8'h34 |-> s_axi_bresp == 2'b10)
		else $error("unmapped write not refused");
	a_read_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped early");
endmodule
bind usb_bus_ctrl usb_bus_ctrl_props u_props (.mclk(mclk), .sys_rst(sys_rst),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.line_speed(line_speed), .drive_reset(drive_reset),
	.drive_resume(drive_resume), .bus_suspended(bus_suspended));

// file: usb_peer_model.sv
// attached usb peer: presents a speed, raises events, times signalling
`timescale 1ns/1ps
module usb_peer_model (
	input  wire logic        mclk,         // system clock
	input  wire logic        drive_reset,  // reset signalling seen
	input  wire logic        drive_resume, // resume signalling seen
	input  wire logic [1:0]  speed_sel,    // speed this peer presents
	input  wire logic [11:0] ctl_req,      // control events to raise
	input  wire logic [31:0] ep_req,       // endpoint events to raise
	output logic [1:0]       line_speed,   // speed shown to the block
	output logic [11:0]      ctl_events,   // one-cycle event pulses
	output logic [31:0]      ep_events,    // one-cycle endpoint pulses
	output int               reset_len,    // cycles of last reset
	output int               resume_len    // cycles of last resume
);
	logic rst_on = 0; // reset seen last cycle
	logic res_on = 0; // resume seen last cycle
	// a peer held in reset cannot report its speed yet
	always_ff @(posedge mclk) begin
		line_speed <= drive_reset ? 2'b00 : speed_sel;
		ctl_events <= ctl_req;
		ep_events <= ep_req;
	end
	// measure how long each signalling spell lasts on the wire
	always_ff @(posedge mclk) begin
		rst_on <= drive_reset;
		res_on <= drive_resume;
		if (drive_reset) reset_len <= rst_on ? reset_len + 1 : 1;
		if (drive_resume) resume_len <= res_on ? resume_len + 1 : 1;
	end
endmodule

// file: testbench.sv
// self-checking bench for the bus-state and interrupt-mask block
`timescale 1ns/1ps
module testbench;
	localparam int HOLD_RST = 40; // scaled-down reset hold
	localparam int HOLD_DEV = 30; // scaled-down device resume hold
	localparam int HOLD_HST = 40; // scaled-down host resume hold
	logic mclk = 0, sys_rst = 1, clk_en = 1, awvalid = 0, wvalid = 0;
	logic bready = 0, arvalid = 0, rready = 0, awready, wready, bvalid;
	logic arready, rvalid, drive_reset, drive_resume, bus_suspended, usb_irq;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, ep_req = 0, rd, rdata, ep_events;
	logic [11:0] ctl_req = 0, ctl_events;
	logic [1:0] bresp, rresp, wr_resp, rd_resp, line_speed, speed_sel = 2;
	int err_count = 0, checks_done = 0, cyc = 0, t_take, t1;
	int reset_len, resume_len;
	always #2.5 mclk = ~mclk;
	always @(posedge mclk) cyc <= cyc + 1;
	usb_bus_ctrl DUT (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .line_speed(line_speed),
		.ctl_events(ctl_events), .ep_events(ep_events),
		.drive_reset(drive_reset), .drive_resume(drive_resume),
		.bus_suspended(bus_suspended), .usb_irq(usb_irq));
	usb_peer_model peer (.mclk(mclk), .drive_reset(drive_reset),
		.drive_resume(drive_resume), .speed_sel(speed_sel),
		.ctl_req(ctl_req), .ep_req(ep_req), .line_speed(line_speed),
		.ctl_events(ctl_events), .ep_events(ep_events),
		.reset_len(reset_len), .resume_len(resume_len));
	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// write both halves at once, release each as it is taken
	task automatic wr(logic [7:0] a, logic [31:0] d);
		logic pa, pw, ta, tw;
		pa = 1;
		pw = 1;
		@(posedge mclk);
		awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
		while (pa || pw) begin
			@(negedge mclk);
			ta = pa && awready;
			tw = pw && wready;
			t_take = cyc;
			@(posedge mclk);
			if (ta) begin awvalid <= 0; pa = 0; end
			if (tw) begin wvalid <= 0; pw = 0; end
		end
		do @(negedge mclk); while (!bvalid);
		wr_resp = bresp;
		@(posedge mclk);
		bready <= 0;
	endtask
	task automatic rd_reg(logic [7:0] a);
		@(posedge mclk);
		araddr <= a; arvalid <= 1; rready <= 1;
		do @(negedge mclk); while (!arready);
		@(posedge mclk);
		arvalid <= 0;
		do @(negedge mclk); while (!rvalid);
		rd = rdata;
		rd_resp = rresp;
		@(posedge mclk);
		rready <= 0;
	endtask
	task automatic wr_rd(logic [7:0] a, logic [31:0] d, logic [7:0] ra,
		logic [31:0] exp);
		wr(a, d);
		rd_reg(ra);
		check("readback", rd, exp);
	endtask
	// one-cycle event request, then let status and the irq lag settle
	task automatic raise(logic [11:0] c, logic [31:0] e);
		@(posedge mclk);
		ctl_req <= c; ep_req <= e;
		@(posedge mclk);
		ctl_req <= 0; ep_req <= 0;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
	endtask
	task automatic t_reset;
		wr(usb_bus_pkg::ADDR_BUS_CTRL, 32'h0000_0009);
		t1 = t_take;
		@(negedge mclk); check("reset on", drive_reset, 1);
		repeat (HOLD_RST) @(posedge mclk);
		@(negedge mclk); check("reset held", drive_reset, 1);
		wr(usb_bus_pkg::ADDR_BUS_CTRL, 32'h0000_0008);
		@(negedge mclk); check("reset off", drive_reset, 0);
		check("reset len", reset_len, t_take - t1);
		$display("test bus reset ended");
	endtask
	task automatic t_resume;
		for (int m = 0; m < 2; m++) begin
			wr(usb_bus_pkg::ADDR_BUS_CTRL, m ? 32'h0000_000A : 32'h0000_0002);
			t1 = t_take;
			@(negedge mclk); check("resume on", drive_resume, 1);
			repeat (m ? HOLD_HST : HOLD_DEV) @(posedge mclk);
			wr(usb_bus_pkg::ADDR_BUS_CTRL, m ? 32'h0000_0008 : 32'h0000_0000);
			@(negedge mclk); check("resume off", drive_resume, 0);
			check("resume len", resume_len, t_take - t1);
		end
		wr(usb_bus_pkg::ADDR_BUS_CTRL, 32'h0000_0004);
		@(negedge mclk); check("dev suspend", bus_suspended, 0);
		wr(usb_bus_pkg::ADDR_BUS_CTRL, 32'h0000_000C);
		@(negedge mclk); check("suspend", bus_suspended, 1);
		wr(usb_bus_pkg::ADDR_BUS_CTRL, 32'h0000_0002);
		@(negedge mclk); check("wake", {bus_suspended, drive_resume}, 1);
		wr(usb_bus_pkg::ADDR_BUS_CTRL, 32'h0000_0008);
		$display("test resume and suspend ended");
	endtask
	task automatic t_speed;
		for (int i = 0; i < 4; i++) begin
			speed_sel <= i[1:0];
			// let the new code pass the peer and the speed register first
			repeat (3) @(posedge mclk);
			rd_reg(usb_bus_pkg::ADDR_BUS_STAT);
			check("speed", rd[1:0], (i == 1 || i == 2) ? i[1:0] : 2'b00);
			check("state idle", rd[3:2], 0);
		end
		$display("test speed ended");
	endtask
	task automatic t_masks;
		wr_rd(8'h08, 32'h7FFF_0F0F, 8'h10, 32'h0001_0F0F);
		wr_rd(8'h0C, 32'h0000_0F00, 8'h10, 32'h0001_000F);
		wr_rd(8'h08, 32'h8000_0000, 8'h10, 32'h0001_FFFF);
		wr_rd(8'h0C, 32'h8000_0000, 8'h10, 32'h0000_0000);
		wr_rd(8'h14, 32'hFFFF_FFFF, 8'h1C, 32'h0000_0FFF);
		wr_rd(8'h18, 32'h0000_0008, 8'h1C, 32'h0000_0FF7);
		for (int i = 0; i < 12; i++) begin
			raise(12'h001 << i, 0);
			check("ctl irq", usb_irq, i != 3);
			rd_reg(usb_bus_pkg::ADDR_CTL_STAT);
			check("ctl stat", rd, 32'h1 << i);
			rd_reg(usb_bus_pkg::ADDR_CTL_STAT);
			check("ctl again", rd, 0);
			@(negedge mclk); check("irq clear", usb_irq, 0);
		end
		wr_rd(8'h24, 32'hFFFF_FFFF, 8'h2C, 32'hFFFF_FFFF);
		wr_rd(8'h28, 32'h0000_FFFF, 8'h2C, 32'hFFFF_0000);
		rd_reg(8'h1C); check("ctl kept", rd, 32'h0000_0FF7);
		raise(0, 32'h0000_0004); check("ep masked", usb_irq, 0);
		raise(0, 32'h0010_0000); check("ep irq", usb_irq, 1);
		wr(usb_bus_pkg::ADDR_EP_STAT, 32'h0010_0000);
		repeat (2) @(posedge mclk);
		@(negedge mclk); check("ep clear", usb_irq, 0);
		rd_reg(8'h34); check("grp stat", rd, 32'h0001_0004);
		// the bench plays the system controller with this line enabled
		wr_rd(8'h08, 32'h0000_0004, 8'h10, 32'h0000_0004);
		@(negedge mclk); check("grp irq", usb_irq, 1);
		wr(8'h34, 32'h0000_0004);
		repeat (2) @(posedge mclk);
		@(negedge mclk); check("grp clear", usb_irq, 0);
		wr(8'h38, 32'h0000_0001); check("wr err", wr_resp, 2'b10);
		rd_reg(8'h3C); check("rd err", rd_resp, 2'b10);
		$display("test masks and irq ended");
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// watchdog: the whole sequence needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge mclk);
		err_count++;
		$display("watchdog expired");
		print_verdict;
	end
	initial begin
		repeat (8) @(posedge mclk);
		sys_rst <= 0;
		t_reset;
		t_resume;
		t_speed;
		t_masks;
		print_verdict;
	end
endmodule
